//--- ovf_fault_resp.sv
`timescale 1ns/1ps
module ovf_fault_resp #(
    parameter int OV_TICK = ovf_pkg::OV_TICK_CYC,
    parameter int UV_TICK = ovf_pkg::UV_TICK_CYC
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire ovf_pkg::ovf_cmd_t cmd,
    output ovf_pkg::ovf_rsp_t     rsp,
    input  wire logic [15:0]      vout_code,
    input  wire logic             vout_valid,
    input  wire logic             ramping,
    input  wire logic             run_en,
    input  wire logic             restart,
    output logic                  out_en,
    output logic                  ov_flag,
    output logic                  uv_flag,
    output logic [15:0]           csense_ofs
);

    // =========================================================
    // Parameter checks
    // =========================================================
    if (OV_TICK < 1 || UV_TICK < 1 ||
        OV_TICK * 7 >= (1 << ovf_pkg::CNT_W) ||
        UV_TICK * 7 >= (1 << ovf_pkg::CNT_W)) begin : g_tick_chk
        $error("tick counts out of range");
    end

    localparam logic [ovf_pkg::CNT_W-1:0] OV_TICK_C =
        ovf_pkg::CNT_W'(OV_TICK);
    localparam logic [ovf_pkg::CNT_W-1:0] UV_TICK_C =
        ovf_pkg::CNT_W'(UV_TICK);

    // =========================================================
    // State
    // =========================================================
    typedef struct packed {
        logic [15:0]         csense_ofs;
        logic [15:0]         ov_thresh;
        logic [15:0]         uv_thresh;
        logic [7:0]          ov_resp;
        logic [7:0]          uv_resp;
        ovf_pkg::ovf_ch_t [1:0] ch;
        logic                ov_flag;
        logic                uv_flag;
        logic                out_en;
        ovf_pkg::ovf_rsp_t   rsp;
    } ovf_state_t;

    ovf_state_t s_r;
    ovf_state_t s_nxt;

    // =========================================================
    // Functions
    // =========================================================
    // Expected data length of a command code
    function automatic logic [1:0] cmd_len(input logic [7:0] code);
        unique case (code)
            ovf_pkg::CMD_CLEAR_FAULTS: cmd_len = ovf_pkg::LEN_SEND;
            ovf_pkg::CMD_CSENSE_OFS,
            ovf_pkg::CMD_OV_THRESH,
            ovf_pkg::CMD_UV_THRESH:    cmd_len = ovf_pkg::LEN_WORD;
            ovf_pkg::CMD_OV_RESP,
            ovf_pkg::CMD_UV_RESP,
            ovf_pkg::CMD_FAULT_STATUS: cmd_len = ovf_pkg::LEN_BYTE;
            default:                   cmd_len = ovf_pkg::LEN_NONE;
        endcase
    endfunction

    // Delay field times tick, never below one cycle
    function automatic logic [ovf_pkg::CNT_W-1:0] dly_cyc(
        input logic [2:0]                f,
        input logic [ovf_pkg::CNT_W-1:0] tick
    );
        logic [ovf_pkg::CNT_W-1:0] p;
        p = {{(ovf_pkg::CNT_W-3){1'b0}}, f} * tick;
        dly_cyc = (f == 3'h0) ? {{(ovf_pkg::CNT_W-1){1'b0}}, 1'b1} : p;
    endfunction

    // =========================================================
    // Combinational next state
    // =========================================================
    logic [1:0] fire;
    logic [1:0][1:0] beh;
    logic       clr;

    always_comb begin
        logic [7:0]                resp;
        logic [2:0]                retry;
        logic [ovf_pkg::CNT_W-1:0] dly;
        logic                      cmp;
        logic                      shut;
        logic                      all_ok;
        resp   = 8'h00;
        retry  = 3'h0;
        dly    = '0;
        cmp    = 1'b0;
        shut   = 1'b0;
        all_ok = 1'b1;
        s_nxt  = s_r;
        fire   = 2'b00;
        beh    = 4'h0;
        clr    = 1'b0;
        s_nxt.rsp.valid = 1'b0;
        s_nxt.rsp.err   = 1'b0;

        // Command decode and register access
        if (cmd.valid) begin
            if (cmd_len(cmd.code) != cmd.len ||
                cmd_len(cmd.code) == ovf_pkg::LEN_NONE ||
                (cmd.write && cmd.code == ovf_pkg::CMD_FAULT_STATUS) ||
                (!cmd.write && cmd.code == ovf_pkg::CMD_CLEAR_FAULTS)) begin
                s_nxt.rsp.err = 1'b1;
            end else if (cmd.write) begin
                unique case (cmd.code)
                    ovf_pkg::CMD_CLEAR_FAULTS: clr = 1'b1;
                    ovf_pkg::CMD_CSENSE_OFS:
                        s_nxt.csense_ofs = cmd.data;
                    ovf_pkg::CMD_OV_THRESH:  s_nxt.ov_thresh = cmd.data;
                    ovf_pkg::CMD_UV_THRESH:  s_nxt.uv_thresh = cmd.data;
                    ovf_pkg::CMD_OV_RESP:  s_nxt.ov_resp = cmd.data[7:0];
                    ovf_pkg::CMD_UV_RESP:  s_nxt.uv_resp = cmd.data[7:0];
                    default: s_nxt.rsp.err = 1'b1;
                endcase
            end else begin
                s_nxt.rsp.valid = 1'b1;
                unique case (cmd.code)
                    ovf_pkg::CMD_CSENSE_OFS: s_nxt.rsp.data = s_r.csense_ofs;
                    ovf_pkg::CMD_OV_THRESH:  s_nxt.rsp.data = s_r.ov_thresh;
                    ovf_pkg::CMD_UV_THRESH:  s_nxt.rsp.data = s_r.uv_thresh;
                    ovf_pkg::CMD_OV_RESP:    s_nxt.rsp.data = {8'h00, s_r.ov_resp};
                    ovf_pkg::CMD_UV_RESP:    s_nxt.rsp.data = {8'h00, s_r.uv_resp};
                    default: begin
                        s_nxt.rsp.data = 16'h0000;
                        s_nxt.rsp.data[ovf_pkg::STAT_OV] = s_r.ov_flag;
                        s_nxt.rsp.data[ovf_pkg::STAT_UV] = s_r.uv_flag;
                    end
                endcase
            end
        end

        // Per-fault response engines, 0 = overvoltage, 1 = undervoltage
        for (int i = 0; i < 2; i++) begin
            resp = (i == 0) ? s_r.ov_resp : s_r.uv_resp;
            retry = resp[ovf_pkg::RETRY_HI:ovf_pkg::RETRY_LO];
            dly = dly_cyc(resp[ovf_pkg::DLY_HI:ovf_pkg::DLY_LO],
                          (i == 0) ? OV_TICK_C : UV_TICK_C);
            beh[i] = resp[ovf_pkg::BEH_HI:ovf_pkg::BEH_LO];
            if (i == 0 && beh[i] == ovf_pkg::BEH_IGNORE) begin
                beh[i] = ovf_pkg::BEH_DISABLE;
            end
            if (i == 0) begin
                cmp = vout_code > s_r.ov_thresh;
            end else begin
                cmp = vout_code < s_r.uv_thresh && !ramping &&
                      s_r.out_en;
            end
            if (vout_valid) begin
                s_nxt.ch[i].cond = cmp;
                fire[i] = cmp;
            end
            shut = 1'b0;
            unique case (s_r.ch[i].st)
                ovf_pkg::CH_RUN: begin
                    if (restart) begin
                        s_nxt.ch[i].used = 3'h0;
                    end
                    if (fire[i]) begin
                        unique case (beh[i])
                            ovf_pkg::BEH_IGNORE: ;
                            ovf_pkg::BEH_DELAY: begin
                                s_nxt.ch[i].st  = ovf_pkg::CH_DLY;
                                s_nxt.ch[i].cnt = dly;
                            end
                            ovf_pkg::BEH_DISABLE: shut = 1'b1;
                            ovf_pkg::BEH_HOLD:
                                s_nxt.ch[i].st = ovf_pkg::CH_HOLD;
                        endcase
                    end
                end
                ovf_pkg::CH_DLY: begin
                    s_nxt.ch[i].cnt = s_r.ch[i].cnt - 1'b1;
                    if (s_r.ch[i].cnt == 1) begin
                        shut = 1'b1;
                    end
                end
                ovf_pkg::CH_OFF: begin
                    s_nxt.ch[i].cnt = s_r.ch[i].cnt - 1'b1;
                    if (s_r.ch[i].cnt == 1) begin
                        s_nxt.ch[i].st = ovf_pkg::CH_RUN;
                    end
                end
                ovf_pkg::CH_HOLD: begin
                    if (!s_nxt.ch[i].cond) begin
                        s_nxt.ch[i].st = ovf_pkg::CH_RUN;
                    end
                end
                ovf_pkg::CH_LATCH: begin
                    if (restart) begin
                        s_nxt.ch[i].st   = ovf_pkg::CH_RUN;
                        s_nxt.ch[i].used = 3'h0;
                    end
                end
                default: s_nxt.ch[i].st = ovf_pkg::CH_RUN;
            endcase
            // Shutdown: retry if budget remains, else latch off
            if (shut) begin
                if (retry == ovf_pkg::RETRY_NONE ||
                    (retry != ovf_pkg::RETRY_CONT &&
                     s_r.ch[i].used >= retry)) begin
                    s_nxt.ch[i].st = ovf_pkg::CH_LATCH;
                end else begin
                    s_nxt.ch[i].st  = ovf_pkg::CH_OFF;
                    s_nxt.ch[i].cnt = dly;
                    if (retry != ovf_pkg::RETRY_CONT) begin
                        s_nxt.ch[i].used = s_r.ch[i].used + 3'h1;
                    end
                end
            end
            // Disable ends any running sequence except a latch
            if (!run_en && s_r.ch[i].st != ovf_pkg::CH_LATCH) begin
                s_nxt.ch[i].st   = ovf_pkg::CH_RUN;
                s_nxt.ch[i].used = 3'h0;
            end
            if (s_nxt.ch[i].st != ovf_pkg::CH_RUN &&
                s_nxt.ch[i].st != ovf_pkg::CH_DLY) begin
                all_ok = 1'b0;
            end
        end

        // Sticky flags: set wins over clear, held condition re-sets
        s_nxt.ov_flag = (s_r.ov_flag & ~clr) | fire[0] |
                        s_nxt.ch[0].cond;
        s_nxt.uv_flag = (s_r.uv_flag & ~clr) | fire[1] |
                        s_nxt.ch[1].cond;
        s_nxt.out_en  = run_en & all_ok;
    end

    // =========================================================
    // State register
    // =========================================================
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r            <= '0;
            s_r.csense_ofs <= ovf_pkg::RST_CSENSE_OFS;
            s_r.ov_thresh  <= ovf_pkg::RST_OV_THRESH;
            s_r.uv_thresh  <= ovf_pkg::RST_UV_THRESH;
            s_r.ov_resp    <= ovf_pkg::RST_RESP;
            s_r.uv_resp    <= ovf_pkg::RST_RESP;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign rsp        = s_r.rsp;
    assign out_en     = s_r.out_en;
    assign ov_flag    = s_r.ov_flag;
    assign uv_flag    = s_r.uv_flag;
    assign csense_ofs = s_r.csense_ofs;

    // =========================================================
    // Assertions
    // =========================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_ov_never_ignored: assert property (
        (s_r.ch[0].st == ovf_pkg::CH_RUN && fire[0] && run_en &&
         s_r.ov_resp[7:6] == ovf_pkg::BEH_IGNORE)
        |=> s_r.ch[0].st != ovf_pkg::CH_RUN)
        else $error("overvoltage was ignored");

    a_ignore_keeps_on: assert property (
        (s_r.ch[1].st == ovf_pkg::CH_RUN && fire[1] &&
         s_r.uv_resp[7:6] == ovf_pkg::BEH_IGNORE)
        |=> s_r.ch[1].st == ovf_pkg::CH_RUN && s_r.uv_flag)
        else $error("ignored fault changed state or not recorded");

    a_delay_entry: assert property (
        (s_r.ch[0].st == ovf_pkg::CH_RUN && fire[0] && run_en &&
         s_r.ch[1].st == ovf_pkg::CH_RUN && !fire[1] &&
         s_r.ov_resp[7:6] == ovf_pkg::BEH_DELAY)
        |=> s_r.ch[0].st == ovf_pkg::CH_DLY && s_r.out_en)
        else $error("delay response not entered");

    a_immediate_off: assert property (
        (s_r.ch[0].st == ovf_pkg::CH_RUN && fire[0] &&
         s_r.ov_resp[7:6] == ovf_pkg::BEH_DISABLE)
        |=> !s_r.out_en)
        else $error("output not disabled at once");

    a_hold_off: assert property (
        s_r.ch[0].st == ovf_pkg::CH_HOLD |-> !s_r.out_en)
        else $error("output on during hold");

    a_latch_stays: assert property (
        (s_r.ch[0].st == ovf_pkg::CH_LATCH && !restart)
        |=> s_r.ch[0].st == ovf_pkg::CH_LATCH && !s_r.out_en)
        else $error("latched output restarted");

    a_spacing_holds: assert property (
        (s_r.ch[0].st == ovf_pkg::CH_OFF && s_r.ch[0].cnt > 1 && run_en)
        |=> s_r.ch[0].st == ovf_pkg::CH_OFF &&
            s_r.ch[0].cnt == $past(s_r.ch[0].cnt) - 1'b1)
        else $error("restart spacing cut short");

    a_sticky_set: assert property (
        (fire[0] || (s_r.ov_flag && !clr)) |=> s_r.ov_flag)
        else $error("sticky flag not held");

    a_uv_masked: assert property (
        (vout_valid && (ramping || !s_r.out_en)) |=> !s_r.ch[1].cond)
        else $error("undervoltage seen while masked");

    c_retry_cycle: cover property (
        s_r.ch[0].st == ovf_pkg::CH_OFF ##1
        s_r.ch[0].st == ovf_pkg::CH_RUN);
    c_delay_shut: cover property (
        s_r.ch[0].st == ovf_pkg::CH_DLY ##1
        s_r.ch[0].st == ovf_pkg::CH_LATCH);
    c_hold_release: cover property (
        s_r.ch[0].st == ovf_pkg::CH_HOLD ##1
        s_r.ch[0].st == ovf_pkg::CH_RUN);

endmodule // ovf_fault_resp

//--- ovf_fault_resp_tb.sv
`timescale 1ns/1ps
// =========================================================
// Self-checking bench for the output fault response block
// =========================================================
module ovf_fault_resp_tb;
    localparam int TICK = 2;
    typedef struct packed {
        logic        w;
        logic [1:0]  len;
        logic [7:0]  code;
        logic [15:0] d;
        logic [1:0]  ans;
    } ovf_row_t;
    logic              core_clk, rst_n, vout_valid, ramping, run_en;
    logic              restart, out_en, ov_flag, uv_flag;
    logic [15:0]       vout_code, csense_ofs, rd;
    logic [1:0]        ans;
    ovf_pkg::ovf_cmd_t cmd;
    ovf_pkg::ovf_rsp_t rsp;
    ovf_row_t          rows [14];
    int                failures, compares;

    // Design and bus host
    ovf_fault_resp #(.OV_TICK(TICK), .UV_TICK(TICK)) ovf_fault_resp_inst (
        .core_clk(core_clk), .rst_n(rst_n), .cmd(cmd), .rsp(rsp),
        .vout_code(vout_code), .vout_valid(vout_valid), .ramping(ramping),
        .run_en(run_en), .restart(restart), .out_en(out_en),
        .ov_flag(ov_flag), .uv_flag(uv_flag), .csense_ofs(csense_ofs));
    ovf_host_model ovf_host_model_inst (
        .core_clk(core_clk), .cmd(cmd), .rsp(rsp));

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic conclude();
        if (failures == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [1:0] len, input logic [7:0] c,
                      input logic [15:0] d);
        ovf_host_model_inst.xfer(1'b1, len, c, d, ans, rd);
    endtask

    task automatic sample(input logic [15:0] v);
        @(negedge core_clk);
        vout_code  = v;
        vout_valid = 1'b1;
        @(negedge core_clk);
        vout_valid = 1'b0;
    endtask

    task automatic pulse_restart();
        @(negedge core_clk);
        restart = 1'b1;
        @(negedge core_clk);
        restart = 1'b0;
    endtask

    // Bounded wait for the output enable level
    task automatic wait_en(input logic v, input int lim);
        int n;
        n = 0;
        while (out_en !== v && n < lim) begin
            @(negedge core_clk);
            n++;
        end
        chk("out_en", {15'h0000, out_en}, {15'h0000, v});
        if (out_en !== v) conclude();
    endtask

    // Main sequence
    initial begin
        rows = '{
            '{1'b0, 2'h2, 8'h39, 16'hBE00, 2'h2},
            '{1'b0, 2'h1, 8'h41, 16'h0080, 2'h2},
            '{1'b0, 2'h1, 8'h45, 16'h0080, 2'h2},
            '{1'b1, 2'h2, 8'h39, 16'h1234, 2'h0},
            '{1'b0, 2'h2, 8'h39, 16'h1234, 2'h2},
            '{1'b1, 2'h2, 8'h40, 16'h8000, 2'h0},
            '{1'b0, 2'h2, 8'h40, 16'h8000, 2'h2},
            '{1'b1, 2'h2, 8'h44, 16'h1000, 2'h0},
            '{1'b0, 2'h2, 8'h44, 16'h1000, 2'h2},
            '{1'b0, 2'h1, 8'h40, 16'h0000, 2'h1},
            '{1'b0, 2'h0, 8'h03, 16'h0000, 2'h1},
            '{1'b1, 2'h1, 8'h7A, 16'h0000, 2'h1},
            '{1'b0, 2'h2, 8'h50, 16'h0000, 2'h1},
            '{1'b1, 2'h1, 8'h45, 16'h0080, 2'h0}};
        failures = 0;
        compares = 0;
        rst_n = 1'b0;
        vout_valid = 1'b0;
        vout_code = 16'h4000;
        ramping = 1'b0;
        run_en = 1'b1;
        restart = 1'b0;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        chk("csense_ofs", csense_ofs, 16'hBE00);
        wait_en(1'b1, 4);
        // Register table rows
        foreach (rows[i]) begin
            ovf_host_model_inst.xfer(rows[i].w, rows[i].len, rows[i].code,
                                     rows[i].d, ans, rd);
            chk("ans", {14'h0000, ans}, {14'h0000, rows[i].ans});
            if (rows[i].ans == 2'h2) chk("rd", rd, rows[i].d);
        end
        chk("csense_ofs", csense_ofs, 16'h1234);
        // Overvoltage with ignore code still shuts down and latches
        wr(2'h1, 8'h41, 16'h0000);
        sample(16'h9000);
        wait_en(1'b0, 4);
        chk("ov_flag", {15'h0000, ov_flag}, 16'h0001);
        ovf_host_model_inst.xfer(1'b0, 2'h1, 8'h7A, 16'h0000, ans, rd);
        chk("status", rd, 16'h0080);
        sample(16'h4000);
        repeat (20) @(negedge core_clk);
        chk("out_en", {15'h0000, out_en}, 16'h0000);
        chk("ov_flag", {15'h0000, ov_flag}, 16'h0001);
        wr(2'h0, ovf_pkg::CMD_CLEAR_FAULTS, 16'h0000);
        chk("ov_flag", {15'h0000, ov_flag}, 16'h0000);
        chk("out_en", {15'h0000, out_en}, 16'h0000);
        pulse_restart();
        wait_en(1'b1, 4);
        // Undervoltage ignored, then masked while ramping
        wr(2'h1, 8'h45, 16'h0000);
        sample(16'h0800);
        repeat (3) @(negedge core_clk);
        chk("uv_flag", {15'h0000, uv_flag}, 16'h0001);
        chk("out_en", {15'h0000, out_en}, 16'h0001);
        ramping = 1'b1;
        sample(16'h0800);
        wr(2'h0, ovf_pkg::CMD_CLEAR_FAULTS, 16'h0000);
        ramping = 1'b0;
        chk("uv_flag", {15'h0000, uv_flag}, 16'h0000);
        // Delayed disable, delay field 3
        wr(2'h1, 8'h41, 16'h0043);
        sample(16'h9000);
        repeat (5) @(negedge core_clk);
        chk("out_en", {15'h0000, out_en}, 16'h0001);
        wait_en(1'b0, 1);
        sample(16'h4000);
        wr(2'h0, ovf_pkg::CMD_CLEAR_FAULTS, 16'h0000);
        pulse_restart();
        wait_en(1'b1, 4);
        // Two retries, third shutdown latches
        wr(2'h1, 8'h41, 16'h0092);
        for (int i = 0; i < 3; i++) begin
            sample(16'h9000);
            wait_en(1'b0, 4);
            sample(16'h4000);
            repeat (14) @(negedge core_clk);
            chk("out_en", {15'h0000, out_en}, (i < 2) ? 16'h1 : 16'h0);
        end
        pulse_restart();
        wait_en(1'b1, 4);
        // Continuous retry with the fault still present
        wr(2'h1, 8'h41, 16'h00BA);
        for (int i = 0; i < 8; i++) begin
            sample(16'h9000); // Fault still present at each restart
            wait_en(1'b0, 4);
            wait_en(1'b1, 6);
        end
        // Hold off while present, re-enable once gone
        wr(2'h1, 8'h41, 16'h00C0);
        sample(16'h9000);
        wait_en(1'b0, 4);
        sample(16'h9000);
        repeat (6) @(negedge core_clk);
        chk("out_en", {15'h0000, out_en}, 16'h0000);
        sample(16'h4000);
        wait_en(1'b1, 6);
        // Reset in mid-run restores defaults
        rst_n = 1'b0;
        @(negedge core_clk);
        chk("csense_ofs", csense_ofs, 16'hBE00);
        chk("ov_flag", {15'h0000, ov_flag}, 16'h0000);
        chk("out_en", {15'h0000, out_en}, 16'h0000);
        rst_n = 1'b1;
        wait_en(1'b1, 4);
        ovf_host_model_inst.xfer(1'b0, 2'h1, 8'h41, 16'h0000, ans, rd);
        chk("rd", rd, 16'h0080);
        conclude();
    end
endmodule // ovf_fault_resp_tb

//--- ovf_host_model.sv
`timescale 1ns/1ps
// =========================================================
// Bus host stand-in: issues byte, word and send-byte commands
// =========================================================
module ovf_host_model (
    input  wire logic              core_clk,
    output ovf_pkg::ovf_cmd_t      cmd,
    input  wire ovf_pkg::ovf_rsp_t rsp
);
    // Idle command word at time zero
    initial begin
        cmd = '0;
    end

    // One transfer: launch on falling edge, answer read on the next falling edge, half a cycle after take
    task automatic xfer(input  logic        w,
                        input  logic [1:0]  len,
                        input  logic [7:0]  code,
                        input  logic [15:0] d,
                        output logic [1:0]  ans,
                        output logic [15:0] rd);
        @(negedge core_clk);
        cmd.valid = 1'b1; // Send byte carries no data when len is 0
        cmd.write = w;
        cmd.len   = len;
        cmd.code  = code;
        cmd.data  = d;
        @(negedge core_clk);
        ans = {rsp.valid, rsp.err}; // Answer stands one cycle only
        rd  = rsp.data;
        cmd.valid = 1'b0;
        cmd.data  = ~d; // Released data no longer shows the last value
    endtask
endmodule // ovf_host_model

//--- ovf_pkg.sv
package ovf_pkg;

    // =========================================================
    // Command codes
    // =========================================================
    localparam logic [7:0] CMD_CLEAR_FAULTS  = 8'h03;
    localparam logic [7:0] CMD_CSENSE_OFS    = 8'h39;
    localparam logic [7:0] CMD_OV_THRESH     = 8'h40;
    localparam logic [7:0] CMD_OV_RESP       = 8'h41;
    localparam logic [7:0] CMD_UV_THRESH     = 8'h44;
    localparam logic [7:0] CMD_UV_RESP       = 8'h45;
    localparam logic [7:0] CMD_FAULT_STATUS  = 8'h7A;

    // =========================================================
    // Transaction lengths in data bytes
    // =========================================================
    localparam logic [1:0] LEN_SEND  = 2'h0;
    localparam logic [1:0] LEN_BYTE  = 2'h1;
    localparam logic [1:0] LEN_WORD  = 2'h2;
    localparam logic [1:0] LEN_NONE  = 2'h3;

    // =========================================================
    // Reset values
    // =========================================================
    localparam logic [15:0] RST_CSENSE_OFS = 16'hBE00;
    localparam logic [15:0] RST_OV_THRESH  = 16'hFFFF;
    localparam logic [15:0] RST_UV_THRESH  = 16'h0000;
    localparam logic [7:0]  RST_RESP       = 8'h80;

    // =========================================================
    // Response byte fields
    // =========================================================
    localparam int BEH_HI   = 7;
    localparam int BEH_LO   = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DLY_HI   = 2;
    localparam int DLY_LO   = 0;

    localparam logic [1:0] BEH_IGNORE  = 2'h0;
    localparam logic [1:0] BEH_DELAY   = 2'h1;
    localparam logic [1:0] BEH_DISABLE = 2'h2;
    localparam logic [1:0] BEH_HOLD    = 2'h3;
    localparam logic [2:0] RETRY_NONE  = 3'h0;
    localparam logic [2:0] RETRY_CONT  = 3'h7;

    // Status byte bit positions
    localparam int STAT_OV = 7;
    localparam int STAT_UV = 6;

    // =========================================================
    // Timing: delay field unit per fault, in ns at 100 MHz
    // =========================================================
    localparam int CLK_PERIOD_NS = 10;
    localparam int OV_UNIT_NS    = 1000;
    localparam int UV_UNIT_NS    = 10000;
    localparam int OV_TICK_CYC   = (OV_UNIT_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int UV_TICK_CYC   = (UV_UNIT_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int CNT_W         = 24;

    // =========================================================
    // Types
    // =========================================================
    typedef enum logic [2:0] {
        CH_RUN, CH_DLY, CH_OFF, CH_LATCH, CH_HOLD
    } ovf_ch_st_t;

    typedef struct packed {
        ovf_ch_st_t         st;
        logic [CNT_W-1:0]   cnt;
        logic [2:0]         used;
        logic               cond;
    } ovf_ch_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [1:0]  len;
        logic [7:0]  code;
        logic [15:0] data;
    } ovf_cmd_t;

    typedef struct packed {
        logic        valid;
        logic        err;
        logic [15:0] data;
    } ovf_rsp_t;

endpackage
